// >>> hdl/ckr_alu.sv
`default_nettype none
module ckr_alu
  import ckr_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input  wire ckr_alu_op_type   i_op,
  input  wire logic [WIDTH-1:0] i_a,
  input  wire logic [WIDTH-1:0] i_b,
  output logic      [WIDTH-1:0] o_result,
  output logic                  o_equal,
  output logic                  o_less
);
  // Signed comparison feeds both set-if-less and branch-if-less.
  assign o_equal = (i_a == i_b);
  assign o_less  = ($signed(i_a) < $signed(i_b));

  // Operation select; an illegal one-hot code yields zero.
  always_comb begin
    unique case (i_op)
      ALU_AND: o_result = i_a & i_b; // see RQ9
      ALU_OR:  o_result = i_a | i_b; // see RQ9
      ALU_ADD: o_result = WIDTH'(i_a + i_b); // see RQ9 and RQ13
      ALU_SUB: o_result = WIDTH'(i_a - i_b); // see RQ9 and RQ13
      ALU_XOR: o_result = i_a ^ i_b; // see RQ10
      ALU_SLT: o_result = {{(WIDTH-1){1'b0}}, o_less}; // see RQ10
      ALU_SLL: o_result = WIDTH'(i_a << i_b); // see RQ12
      ALU_SRL: o_result = WIDTH'(i_a >> i_b); // see RQ12
      ALU_SRA: o_result = WIDTH'($signed(i_a) >>> i_b); // see RQ12
      default: o_result = '0;
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/ckr_core.sv
`default_nettype none
module ckr_core
  import ckr_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_SYS_RST,
  input  wire logic [7:0] I_DEDICATED_INPUTS,
  input  wire logic [7:0] I_BIDIR_IN,
  output logic      [7:0] O_BIDIR_OUT,
  output logic      [7:0] O_BIDIR_OE,
  output logic      [7:0] O_DEDICATED_OUTPUTS,
  output logic            O_ILLEGAL
);
  logic [INSTR_W-1:0] instr;
  logic [1:0]         opcode;
  logic [2:0]         major_function_code;
  logic [1:0]         minor_function_code;
  logic [IDX_W-1:0]   first_source_index;
  logic [IDX_W-1:0]   second_source_index;
  logic [IDX_W-1:0]   dest_index;
  logic [DATA_W-1:0]  first_value;
  logic [DATA_W-1:0]  second_value;
  logic [DATA_W-1:0]  alu_b;
  logic [DATA_W-1:0]  alu_out;
  logic               alu_equal;
  logic               alu_less;
  ckr_alu_op_type     alu_op;
  ckr_class_type      cls;
  logic               branch_taken;
  logic               wr_en;
  logic [DATA_W-1:0]  wr_data;
  logic [DATA_W-1:0]  result_reg;
  logic [DATA_W-1:0]  result_next;
  logic               illegal_reg;

  // The instruction word is assembled from both pin groups; the pins are used as inputs only.
  assign instr       = {I_BIDIR_IN, I_DEDICATED_INPUTS}; // see RQ1 and RQ17
  assign O_BIDIR_OUT = 8'h00;
  assign O_BIDIR_OE  = BIDIR_OE; // see RQ17

  // Field extraction.
  assign opcode              = instr[OPC_MSB:OPC_LSB];
  assign major_function_code = instr[MAJOR_MSB:MAJOR_LSB];
  assign minor_function_code = instr[MINOR_MSB:MINOR_LSB];
  assign first_source_index  = instr[RS1_MSB:RS1_LSB];
  assign second_source_index = instr[RS2_MSB:RS2_LSB];
  assign dest_index          = instr[RD_MSB:RD_LSB];

  // Decode picks the instruction class and the ALU operation.
  always_comb begin
    cls    = CLS_ILLEGAL;
    alu_op = ALU_ADD;
    unique case (opcode)
      OPC_REG_REG: begin
        cls = CLS_REG_REG; // see RQ8
        unique case ({major_function_code, minor_function_code})
          {MAJ_AND, MIN_BASE}: alu_op = ALU_AND; // see RQ9
          {MAJ_OR,  MIN_BASE}: alu_op = ALU_OR;
          {MAJ_ADD, MIN_BASE}: alu_op = ALU_ADD;
          {MAJ_SUB, MIN_BASE}: alu_op = ALU_SUB;
          {MAJ_OR,  MIN_ALT}:  alu_op = ALU_XOR; // see RQ10
          {MAJ_SLT, MIN_BASE}: alu_op = ALU_SLT; // see RQ10
          default:             cls    = CLS_ILLEGAL;
        endcase
      end
      OPC_REG_IMM: begin
        cls = CLS_REG_IMM; // see RQ11
        unique case (major_function_code)
          MAJ_SLL: alu_op = ALU_SLL; // see RQ12
          MAJ_SRL: alu_op = ALU_SRL;
          MAJ_SRA: alu_op = ALU_SRA;
          MAJ_ADD: alu_op = ALU_ADD; // see RQ13
          MAJ_SUB: alu_op = ALU_SUB; // see RQ13
          default: cls    = CLS_ILLEGAL;
        endcase
      end
      OPC_LOAD: begin
        // The first source field must hold zeros.
        if (first_source_index == '0) begin
          cls = CLS_LOAD; // see RQ14
        end
      end
      OPC_SYS: begin
        if (instr[RD_MSB:RD_LSB] != '0) begin
          cls = CLS_ILLEGAL;
        end else if ((instr[STZ_MSB:STZ_LSB] == '0) && (second_source_index == '0)) begin
          cls = CLS_STORE; // see RQ15
        end else if (({major_function_code, minor_function_code} == {MAJ_SUB, MIN_BASE}) ||
                     ({major_function_code, minor_function_code} == {MAJ_SUB, MIN_NE}) ||
                     ({major_function_code, minor_function_code} == {MAJ_SLT, MIN_BASE})) begin
          cls = CLS_BRANCH; // see RQ16
        end
      end
    endcase
  end

  // Second operand is a register for register forms and branches, else the 5-bit immediate.
  assign alu_b = (cls == CLS_REG_IMM) ?
                 DATA_W'(instr[SHIMM_MSB:SHIMM_LSB]) : second_value; // see RQ11

  ckr_regfile #(
    .COUNT (REG_COUNT),
    .WIDTH (DATA_W),
    .AW    (IDX_W)
  ) u_regfile (
    .i_clk       (I_CLK),
    .i_rst       (I_SYS_RST),
    .i_rd_idx_a  (first_source_index),
    .i_rd_idx_b  (second_source_index),
    .o_rd_data_a (first_value),
    .o_rd_data_b (second_value),
    .i_wr_en     (wr_en),
    .i_wr_idx    (dest_index),
    .i_wr_data   (wr_data)
  );

  ckr_alu #(
    .WIDTH (DATA_W)
  ) u_alu (
    .i_op     (alu_op),
    .i_a      (first_value),
    .i_b      (alu_b),
    .o_result (alu_out),
    .o_equal  (alu_equal),
    .o_less   (alu_less)
  );

  // Branch condition from the two source registers.
  always_comb begin
    unique case ({major_function_code, minor_function_code})
      {MAJ_SUB, MIN_BASE}: branch_taken = alu_equal; // see RQ16
      {MAJ_SUB, MIN_NE}:   branch_taken = !alu_equal;
      {MAJ_SLT, MIN_BASE}: branch_taken = alu_less;
      default:             branch_taken = 1'b0;
    endcase
  end

  // Write-back happens on the same edge that executes the instruction.
  assign wr_en   = (cls == CLS_REG_REG) || (cls == CLS_REG_IMM) || (cls == CLS_LOAD); // see RQ18
  assign wr_data = (cls == CLS_LOAD) ? instr[LIMM_MSB:LIMM_LSB] : alu_out; // see RQ14 and RQ18

  // Result value chosen by instruction class.
  always_comb begin
    unique case (cls)
      CLS_STORE:  result_next = first_value; // see RQ6
      CLS_BRANCH: result_next = branch_taken ? TAKEN_VAL : RESULT_RST; // see RQ7
      default:    result_next = RESULT_RST; // see RQ5
    endcase
  end

  // Result register, loaded every edge so the answer follows one clock later.
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      result_reg <= RESULT_RST; // see RQ19
    end else begin
      result_reg <= result_next; // see RQ4
    end
  end

  // Flags an encoding that matches no instruction; such words write no register and drive the result to zero.
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      illegal_reg <= 1'b0;
    end else begin
      illegal_reg <= (cls == CLS_ILLEGAL);
    end
  end

  assign O_DEDICATED_OUTPUTS = result_reg;
  assign O_ILLEGAL           = illegal_reg;
endmodule
`default_nettype wire

// >>> hdl/ckr_pkg.sv
// What this block does
// (RQ1) Instructions are exactly 16 bits in a compressed custom encoding.
// (RQ2) Eight general registers, 8 bits each, selected by 3-bit indices.
// (RQ3) Register index zero always reads as zero, whatever was written.
// (RQ4) Tester presents an instruction, gives one edge; it executes in that cycle.
// (RQ5) Register, immediate and load-immediate instructions drive the result to zero.
// (RQ6) Store drives the result with the register named by the first source.
// (RQ7) Branch drives result one when its condition holds, zero otherwise.
// (RQ8) Register-register format: opcode 00, codes [15:13],[12:11], sources, destination.
// (RQ9) Minor code 00 with major 000..011 selects AND, OR, add, subtract.
// (RQ10) Major 001 minor 01 is XOR; major 111 minor 00 is set-if-less.
// (RQ11) Register-immediate format: opcode 01, major [15:13], unsigned immediate [12:8].
// (RQ12) Immediate codes 100, 101, 110 shift left, right logical, right arithmetic.
// (RQ13) Immediate codes 010 and 011 add or subtract the immediate.
// (RQ14) Load-immediate: opcode 10, signed immediate [15:8], zeros [7:5], destination [4:2].
// (RQ15) Store: opcode 11, zero [15:8], source [7:5], zero [4:2].
// (RQ16) Branch: opcode 11, sources, zero [4:2]; equal, not-equal, less-than codes.
// (RQ17) Low instruction byte on dedicated inputs, high byte on bidirectional pins.
// (RQ18) Load-immediate and ALU results are written on the executing clock edge.
// (RQ19) Reset clears all registers and the result output to zero.
`default_nettype none
package ckr_pkg;
  localparam int unsigned INSTR_W   = 16;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned REG_COUNT = 8;
  localparam int unsigned IDX_W     = 3;
  // Field positions inside the instruction word.
  localparam int unsigned OPC_LSB   = 0;
  localparam int unsigned OPC_MSB   = 1;
  localparam int unsigned RD_LSB    = 2;
  localparam int unsigned RD_MSB    = 4;
  localparam int unsigned RS1_LSB   = 5;
  localparam int unsigned RS1_MSB   = 7;
  localparam int unsigned RS2_LSB   = 8;
  localparam int unsigned RS2_MSB   = 10;
  localparam int unsigned MINOR_LSB = 11;
  localparam int unsigned MINOR_MSB = 12;
  localparam int unsigned MAJOR_LSB = 13;
  localparam int unsigned MAJOR_MSB = 15;
  localparam int unsigned SHIMM_LSB = 8;
  localparam int unsigned SHIMM_MSB = 12;
  localparam int unsigned LIMM_LSB  = 8;
  localparam int unsigned LIMM_MSB  = 15;
  localparam int unsigned STZ_LSB   = 11;
  localparam int unsigned STZ_MSB   = 15;
  // Major opcodes.
  localparam logic [1:0] OPC_REG_REG = 2'h0;
  localparam logic [1:0] OPC_REG_IMM = 2'h1;
  localparam logic [1:0] OPC_LOAD    = 2'h2;
  localparam logic [1:0] OPC_SYS     = 2'h3;
  // Major and minor function codes.
  localparam logic [2:0] MAJ_AND = 3'h0;
  localparam logic [2:0] MAJ_OR  = 3'h1;
  localparam logic [2:0] MAJ_ADD = 3'h2;
  localparam logic [2:0] MAJ_SUB = 3'h3;
  localparam logic [2:0] MAJ_SLL = 3'h4;
  localparam logic [2:0] MAJ_SRL = 3'h5;
  localparam logic [2:0] MAJ_SRA = 3'h6;
  localparam logic [2:0] MAJ_SLT = 3'h7;
  localparam logic [1:0] MIN_BASE = 2'h0;
  localparam logic [1:0] MIN_ALT  = 2'h1;
  localparam logic [1:0] MIN_NE   = 2'h2;
  // Reset, answer and pin-enable values.
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [7:0] TAKEN_VAL  = 8'h01;
  localparam logic [7:0] BIDIR_OE   = 8'h00;

  typedef enum logic [8:0] {
    ALU_AND = 9'h001,
    ALU_OR  = 9'h002,
    ALU_ADD = 9'h004,
    ALU_SUB = 9'h008,
    ALU_XOR = 9'h010,
    ALU_SLT = 9'h020,
    ALU_SLL = 9'h040,
    ALU_SRL = 9'h080,
    ALU_SRA = 9'h100
  } ckr_alu_op_type;

  typedef enum logic [5:0] {
    CLS_REG_REG = 6'h01,
    CLS_REG_IMM = 6'h02,
    CLS_LOAD    = 6'h04,
    CLS_STORE   = 6'h08,
    CLS_BRANCH  = 6'h10,
    CLS_ILLEGAL = 6'h20
  } ckr_class_type;
endpackage
`default_nettype wire

// >>> hdl/ckr_regfile.sv
`default_nettype none
module ckr_regfile
  import ckr_pkg::*;
#(
  parameter int unsigned COUNT = REG_COUNT,
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned AW    = IDX_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [AW-1:0]    i_rd_idx_a,
  input  wire logic [AW-1:0]    i_rd_idx_b,
  output logic      [WIDTH-1:0] o_rd_data_a,
  output logic      [WIDTH-1:0] o_rd_data_b,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_idx,
  input  wire logic [WIDTH-1:0] i_wr_data
);
  logic [WIDTH-1:0] mem_reg [COUNT];

  // Storage; writes to index zero are dropped, reset clears every entry.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < COUNT; i++) begin
        mem_reg[i] <= WIDTH'(REG_RST); // see RQ19
      end
    end else if (i_wr_en && (i_wr_idx != '0)) begin
      mem_reg[i_wr_idx] <= i_wr_data; // see RQ2
    end
  end

  // Index zero reads as zero on both ports.
  assign o_rd_data_a = (i_rd_idx_a == '0) ? '0 : mem_reg[i_rd_idx_a]; // see RQ3
  assign o_rd_data_b = (i_rd_idx_b == '0) ? '0 : mem_reg[i_rd_idx_b]; // see RQ3
endmodule
`default_nettype wire

// >>> tb/ckr_core_monitor.sv
`default_nettype none
module ckr_core_monitor
  import ckr_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_SYS_RST,
  input wire logic [7:0] I_DEDICATED_INPUTS,
  input wire logic [7:0] I_BIDIR_IN,
  input wire logic [7:0] O_BIDIR_OUT,
  input wire logic [7:0] O_BIDIR_OE,
  input wire logic [7:0] O_DEDICATED_OUTPUTS,
  input wire logic       O_ILLEGAL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w;

  // The whole word that the core executes at each edge.
  assign w = {I_BIDIR_IN, I_DEDICATED_INPUTS};

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  // A legal load into a nonzero register.
  sequence load_s;
    w[1:0] == 2'h2 && w[7:5] == 3'h0 && w[4:2] != 3'h0;
  endsequence
  // The next word stores that same register back out.
  sequence store_back_s;
    load_s ##1 (w == {8'h00, $past(w[4:2]), 5'h03});
  endsequence

  reset_clear_a: assert property (@(posedge I_CLK) disable iff (1'b0)
    I_SYS_RST |=> O_DEDICATED_OUTPUTS == 8'h00 && !O_ILLEGAL)
    else $error("output not cleared by reset");
  load_store_a: assert property (store_back_s |=>
    O_DEDICATED_OUTPUTS == $past(w[15:8], 2))
    else $error("stored value differs from loaded value");
  zero_reg_a: assert property (w == 16'h0003 |=> O_DEDICATED_OUTPUTS == 8'h00)
    else $error("zero register read nonzero");
  alu_quiet_a: assert property (w[1:0] != 2'h3 |=> O_DEDICATED_OUTPUTS == 8'h00)
    else $error("nonzero result for non-store word");
  beq_self_a: assert property (
    w[15:11] == 5'h0c && w[10:8] == w[7:5] && w[4:0] == 5'h03 |=> O_DEDICATED_OUTPUTS == 8'h01)
    else $error("equal branch on same register not taken");
  bne_self_a: assert property (
    w[15:11] == 5'h0e && w[10:8] == w[7:5] && w[4:0] == 5'h03 |=> O_DEDICATED_OUTPUTS == 8'h00)
    else $error("not-equal branch on same register taken");
  branch_bit_a: assert property (
    w[4:0] == 5'h03 && w[15:8] != 8'h00 |=> O_DEDICATED_OUTPUTS[7:1] == 7'h00)
    else $error("branch result wider than one bit");
  illegal_load_a: assert property (
    w[1:0] == 2'h2 && w[7:5] != 3'h0 |=> O_ILLEGAL && O_DEDICATED_OUTPUTS == 8'h00)
    else $error("malformed load not flagged");
  pins_input_a: assert property (O_BIDIR_OE == 8'h00 && O_BIDIR_OUT == 8'h00)
    else $error("bidirectional pins driven");
endmodule

bind ckr_core ckr_core_monitor u_mon (
  .I_CLK               (I_CLK),
  .I_SYS_RST           (I_SYS_RST),
  .I_DEDICATED_INPUTS  (I_DEDICATED_INPUTS),
  .I_BIDIR_IN          (I_BIDIR_IN),
  .O_BIDIR_OUT         (O_BIDIR_OUT),
  .O_BIDIR_OE          (O_BIDIR_OE),
  .O_DEDICATED_OUTPUTS (O_DEDICATED_OUTPUTS),
  .O_ILLEGAL           (O_ILLEGAL)
);
`default_nettype wire

// >>> tb/ckr_core_tb_top.sv
`default_nettype none
module ckr_core_tb_top;
  import ckr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [15:0] ins; logic [7:0] exp; } ckr_row_type;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] word = 16'h0000;
  logic [7:0]  low, high, bout, boe, res;
  logic        ill;
  int          num_errors = 0;
  int          checks = 0;
  ckr_row_type rows[$];

  // Free-running bench clock.
  always #5 clk = ~clk;

  ckr_tester u_tester (.i_clk(clk), .i_word(word), .o_low(low), .o_high(high));
  ckr_core dut (.I_CLK(clk), .I_SYS_RST(rst), .I_DEDICATED_INPUTS(low), .I_BIDIR_IN(high),
    .O_BIDIR_OUT(bout), .O_BIDIR_OE(boe), .O_DEDICATED_OUTPUTS(res), .O_ILLEGAL(ill));

  // Word builders for each format.
  function automatic logic [15:0] rr(logic [2:0] f, logic [1:0] m, logic [2:0] b, a, d);
    return {f, m, b, a, d, 2'h0};
  endfunction
  function automatic logic [15:0] ri(logic [2:0] f, logic [4:0] i, logic [2:0] a, d);
    return {f, i, a, d, 2'h1};
  endfunction
  function automatic logic [15:0] ld(logic [7:0] i, logic [2:0] d);
    return {i, 3'h0, d, 2'h2};
  endfunction
  function automatic logic [15:0] st(logic [2:0] a);
    return {8'h00, a, 5'h03};
  endfunction
  function automatic logic [15:0] br(logic [2:0] f, logic [1:0] m, logic [2:0] b, a);
    return {f, m, b, a, 5'h03};
  endfunction

  // One word, one executing edge, then look once the edge has settled.
  // The word changes just off any edge, so the tester never races it at a falling edge.
  task automatic step(input logic [15:0] v);
    #1;
    word = v;
    @(negedge clk);
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cut a hang short well past the expected run length.
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    rows = '{'{ld(8'h03, 2), 8'h00}, '{ld(8'h85, 1), 8'h00}, '{st(1), 8'h85},
      '{ld(8'h7f, 0), 8'h00}, '{st(0), 8'h00}, '{rr(2, 0, 1, 1, 0), 8'h00}, '{st(0), 8'h00},
      '{rr(0, 0, 2, 1, 3), 8'h00}, '{st(3), 8'h01}, '{rr(1, 0, 2, 1, 3), 8'h00}, '{st(3), 8'h87},
      '{rr(1, 1, 2, 1, 3), 8'h00}, '{st(3), 8'h86}, '{rr(2, 0, 2, 1, 3), 8'h00}, '{st(3), 8'h88},
      '{rr(3, 0, 2, 1, 3), 8'h00}, '{st(3), 8'h82}, '{rr(7, 0, 2, 1, 3), 8'h00}, '{st(3), 8'h01},
      '{rr(7, 0, 1, 2, 3), 8'h00}, '{st(3), 8'h00}, '{ri(4, 1, 1, 4), 8'h00}, '{st(4), 8'h0a},
      '{ri(5, 2, 1, 4), 8'h00}, '{st(4), 8'h21}, '{ri(6, 2, 1, 4), 8'h00}, '{st(4), 8'he1},
      '{ri(2, 31, 2, 4), 8'h00}, '{st(4), 8'h22}, '{ri(3, 4, 2, 4), 8'h00}, '{st(4), 8'hff},
      '{ri(4, 9, 1, 4), 8'h00}, '{st(4), 8'h00}, '{br(3, 0, 1, 1), 8'h01},
      '{br(3, 0, 2, 1), 8'h00}, '{br(3, 2, 2, 1), 8'h01}, '{br(3, 2, 1, 1), 8'h00},
      '{br(7, 0, 2, 1), 8'h01}, '{br(7, 0, 1, 2), 8'h00}, '{br(3, 0, 0, 0), 8'h01}};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // Ordinary instructions, each followed by a check of the result pins.
    foreach (rows[i]) begin
      step(rows[i].ins);
      chk($sformatf("row %0d", i), rows[i].exp, res);
    end
    // A word held over three edges executes three times.
    step(ld(8'h01, 5));
    repeat (3) step(rr(2, 0, 5, 5, 5));
    step(st(5));
    chk("held add", 8'h08, res);
    chk("pin enables", 8'h00, boe);
    chk("pin outputs", 8'h00, bout);
    // A malformed load and an unlisted function code are flagged and write nothing.
    step(16'h0126);
    chk("illegal flag", 8'h01, {7'h00, ill});
    step(rr(5, 3, 2, 1, 1));
    chk("bad function", 8'h01, {7'h00, ill});
    step(st(1));
    chk("r1 kept", 8'h85, res);
    chk("legal flag", 8'h00, {7'h00, ill});
    // Reset in mid-run clears result and registers.
    step(ld(8'h5a, 6));
    step(st(6));
    chk("r6 loaded", 8'h5a, res);
    @(negedge clk);
    rst = 1'b1;
    @(posedge clk);
    #1;
    chk("out in reset", 8'h00, res);
    @(negedge clk);
    rst = 1'b0;
    step(st(6));
    chk("r6 cleared", 8'h00, res);
    step(st(1));
    chk("r1 cleared", 8'h00, res);
    results();
  end
endmodule
`default_nettype wire

// >>> tb/ckr_tester.sv
`default_nettype none
module ckr_tester (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_word,
  output logic      [7:0]  o_low,
  output logic      [7:0]  o_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins start at a harmless word so nothing is unknown at time zero.
  initial {o_high, o_low} = 16'h0000;
  // The whole word goes out at the falling edge, ahead of the executing edge.
  always @(negedge i_clk) begin
    o_low  <= i_word[7:0];
    o_high <= i_word[15:8];
  end
endmodule
`default_nettype wire
